// ---- hw/irt_pkg.sv ----
// Package: constants, enums and carriers for the interrupt response sequencer
package irt_pkg;

   // ----------------------------------------------------------------------
   // Phase durations in states (one state is one i_clk cycle)
   // ----------------------------------------------------------------------
   localparam int IRT_PRIO_EXT_STATES  = 2;  // Priority decision, external
   localparam int IRT_PRIO_INT_STATES  = 1;  // Priority decision, on-chip
   localparam int IRT_FIN_MAX_ONCHIP   = 23; // Longest instruction tail
   localparam int IRT_FIN_MAX_EXT2     = 27;
   localparam int IRT_FIN_MAX_EXT3     = 31;
   localparam int IRT_ACC_ONCHIP       = 4;  // Stack, vector, prefetch each
   localparam int IRT_ACC_EXT2         = 8;
   localparam int IRT_ACC_EXT3         = 12;
   localparam int IRT_INTERNAL_STATES  = 4;  // Any memory type
   localparam int IRT_TIMER_W          = 4;  // Holds up to 12 - 1
   localparam int IRT_CYC_W            = 8;  // Assertion helper counter

   // ----------------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      IRT_MEM_ONCHIP,
      IRT_MEM_EXT2,
      IRT_MEM_EXT3
   } irt_mem_type;

   typedef enum logic [1:0] {
      IRT_SRC_NONE,
      IRT_SRC_NMI,
      IRT_SRC_IRQ,
      IRT_SRC_INT
   } irt_src_type;

   typedef enum logic [2:0] {
      IRT_IDLE,
      IRT_PRIO,
      IRT_FINISH,
      IRT_STACK,
      IRT_VECTOR,
      IRT_PREFETCH,
      IRT_INTERNAL
   } irt_phase_type;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic nmi;        // Non-maskable request, level
      logic irq;        // External pin request, level
      logic irq_en;     // Its enable bit
      logic irq_prio1;  // Its priority level is 1
      logic intr;       // On-chip source request, level
      logic intr_en;    // Its enable bit
      logic intr_prio1; // Its priority level is 1
   } irt_req_type;

   typedef struct packed {
      logic wr;         // Load the mask bits this cycle
      logic mask;       // Value for the interrupt mask bit
      logic user_mask;  // Value for the user mask bit
   } irt_mask_wr_type;

endpackage

// ---- hw/irt_state_timer.sv ----
// Down counter that times one phase, with a hold for wait states
module irt_state_timer
   import irt_pkg::*;
#(
   parameter int W = IRT_TIMER_W
)(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   // Control
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_load_value,
   input  wire logic         i_hold,
   // Status
   output logic      [W-1:0] o_count,
   output logic              o_last
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] count; // States left after this one
   } irt_timer_type;

   irt_timer_type st;      // Registered state
   irt_timer_type next_st; // Next state

   // Load wins over hold so a new phase always starts cleanly
   always_comb begin
      next_st = st;
      if (i_load) begin
         next_st.count = i_load_value;
      end else if (!i_hold && st.count != '0) begin
         next_st.count = st.count - W'(1);
      end
   end

   // Register the state
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_count = st.count;
   assign o_last  = (st.count == '0);

endmodule

// ---- hw/irt_exception_seq.sv ----
// Interrupt acceptance and exception sequence timing up to the service routine
module irt_exception_seq
   import irt_pkg::*;
(
   // Clock and reset
   input  wire logic            i_clk,
   input  wire logic            i_resetn,
   // Requests and mode
   input  wire irt_req_type     i_req,
   input  wire logic            i_standby,
   input  wire logic            i_user_bit_enable,
   input  wire irt_mem_type     i_mem_type,
   // CPU progress
   input  wire logic            i_insn_done,
   input  wire logic            i_wait,
   // Mask bit load from the condition flags register
   input  wire irt_mask_wr_type i_mask_wr,
   // Sequence status
   output irt_phase_type        o_phase,
   output irt_src_type          o_source,
   output logic                 o_accept,
   output logic                 o_service_start,
   output logic                 o_busy,
   // Mask bits of the condition flags register
   output logic                 o_int_mask,
   output logic                 o_user_mask_bit
);

   // ----------------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------------
   typedef struct packed {
      irt_phase_type phase;     // Current phase
      irt_src_type   source;    // Accepted source
      irt_mem_type   mem;       // Memory type caught at acceptance
      logic          accept;    // Acceptance pulse
      logic          service;   // First service instruction pulse
      logic          mask;      // Interrupt mask bit
      logic          user_mask; // User mask bit
   } irt_seq_type;

   irt_seq_type              st;         // Registered state
   irt_seq_type              next_st;    // Next state
   logic                     tmr_load;   // Start timing a phase
   logic [IRT_TIMER_W-1:0]   tmr_value;  // Phase length minus one
   logic                     tmr_hold;   // Stretch for a wait state
   logic                     tmr_last;   // Final state of the phase
   logic                     maskable_ok_irq; // Pin request passes masks
   logic                     maskable_ok_int; // On-chip request passes
   logic                     nmi_go;     // NMI can be taken
   logic                     irq_go;     // Pin request can be taken
   logic                     int_go;     // On-chip request can be taken
   logic                     ext_access; // Phase uses external memory

   // Access length minus one for stack, vector and prefetch
   function automatic logic [IRT_TIMER_W-1:0] acc_len(irt_mem_type m);
      unique case (m)
         IRT_MEM_ONCHIP: acc_len = IRT_TIMER_W'(IRT_ACC_ONCHIP - 1);
         IRT_MEM_EXT2:   acc_len = IRT_TIMER_W'(IRT_ACC_EXT2 - 1);
         IRT_MEM_EXT3:   acc_len = IRT_TIMER_W'(IRT_ACC_EXT3 - 1);
         default:        acc_len = IRT_TIMER_W'(IRT_ACC_EXT3 - 1);
      endcase
   endfunction

   // Longest instruction tail for a memory type, used by the checks
   function automatic int fin_max(irt_mem_type m);
      unique case (m)
         IRT_MEM_ONCHIP: fin_max = IRT_FIN_MAX_ONCHIP;
         IRT_MEM_EXT2:   fin_max = IRT_FIN_MAX_EXT2;
         IRT_MEM_EXT3:   fin_max = IRT_FIN_MAX_EXT3;
         default:        fin_max = IRT_FIN_MAX_EXT3;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Acceptance
   // ----------------------------------------------------------------------
   // A masked request is not dropped: it simply waits while still raised
   always_comb begin
      // Standby gates these too, so a held request cannot move o_source
      maskable_ok_irq = !i_standby && (!st.mask ||
         (!i_user_bit_enable && !st.user_mask && i_req.irq_prio1));
      maskable_ok_int = !i_standby && (!st.mask ||
         (!i_user_bit_enable && !st.user_mask && i_req.intr_prio1));
      nmi_go = i_req.nmi && !i_standby;
      irq_go = i_req.irq && i_req.irq_en && maskable_ok_irq;
      int_go = i_req.intr && i_req.intr_en && maskable_ok_int;
   end

   // Only memory phases of an external area see the wait pin
   assign ext_access = (st.mem != IRT_MEM_ONCHIP) &&
      (st.phase inside {IRT_STACK, IRT_VECTOR, IRT_PREFETCH});
   assign tmr_hold   = ext_access && i_wait;

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      next_st         = st;
      next_st.accept  = 1'b0;
      next_st.service = 1'b0;
      tmr_load        = 1'b0;
      tmr_value       = '0;
      // Software load of the mask bits; the hardware set below wins
      if (i_mask_wr.wr) begin
         next_st.mask      = i_mask_wr.mask;
         next_st.user_mask = i_mask_wr.user_mask;
      end
      unique case (st.phase)
         IRT_IDLE: begin
            // NMI first, then pin request, then on-chip sources
            if (nmi_go || irq_go || int_go) begin
               next_st.phase  = IRT_PRIO;
               next_st.accept = 1'b1;
               next_st.mem    = i_mem_type;
               tmr_load       = 1'b1;
               if (nmi_go || irq_go) begin
                  next_st.source = nmi_go ? IRT_SRC_NMI : IRT_SRC_IRQ;
                  tmr_value = IRT_TIMER_W'(IRT_PRIO_EXT_STATES - 1);
               end else begin
                  next_st.source = IRT_SRC_INT;
                  tmr_value = IRT_TIMER_W'(IRT_PRIO_INT_STATES - 1);
               end
            end
         end
         IRT_PRIO: begin
            if (tmr_last) begin
               next_st.phase = IRT_FINISH;
            end
         end
         IRT_FINISH: begin
            // The current instruction must end before any stacking
            if (i_insn_done) begin
               next_st.phase = IRT_STACK;
               next_st.mask  = 1'b1;
               if (!i_user_bit_enable) begin
                  next_st.user_mask = 1'b1;
               end
               tmr_load  = 1'b1;
               tmr_value = acc_len(st.mem);
            end
         end
         IRT_STACK: begin
            if (tmr_last && !tmr_hold) begin
               next_st.phase = IRT_VECTOR;
               tmr_load      = 1'b1;
               tmr_value     = acc_len(st.mem);
            end
         end
         IRT_VECTOR: begin
            if (tmr_last && !tmr_hold) begin
               next_st.phase = IRT_PREFETCH;
               tmr_load      = 1'b1;
               tmr_value     = acc_len(st.mem);
            end
         end
         IRT_PREFETCH: begin
            if (tmr_last && !tmr_hold) begin
               next_st.phase = IRT_INTERNAL;
               tmr_load      = 1'b1;
               tmr_value = IRT_TIMER_W'(IRT_INTERNAL_STATES - 1);
            end
         end
         IRT_INTERNAL: begin
            if (tmr_last) begin
               next_st.phase   = IRT_IDLE;
               next_st.service = 1'b1;
            end
         end
      endcase
      // Standby abandons the sequence; nothing is accepted there
      if (i_standby) begin
         next_st.phase   = IRT_IDLE;
         next_st.accept  = 1'b0;
         next_st.service = 1'b0;
      end
   end

   // Register the state; masks come up set as after a reset
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st           <= '0;
         st.phase     <= IRT_IDLE;
         st.mask      <= 1'b1;
         st.user_mask <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Phase timer
   irt_state_timer #(
      .W            (IRT_TIMER_W)
   ) u_timer (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .i_load       (tmr_load),
      .i_load_value (tmr_value),
      .i_hold       (tmr_hold),
      .o_count      (),
      .o_last       (tmr_last)
   );

   assign o_phase         = st.phase;
   assign o_source        = st.source;
   assign o_accept        = st.accept;
   assign o_service_start = st.service;
   assign o_busy          = (st.phase != IRT_IDLE);
   assign o_int_mask      = st.mask;
   assign o_user_mask_bit = st.user_mask;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [IRT_CYC_W-1:0] cyc;    // Cycles already spent in the phase
   logic                 waited; // A wait state was seen in the phase
   logic                 leave;  // Phase ends at this edge
   assign leave = (next_st.phase != st.phase);

   // Helper counter, reset on every phase change
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cyc    <= '0;
         waited <= 1'b0;
      end else if (leave) begin
         cyc    <= '0;
         waited <= 1'b0;
      end else begin
         cyc    <= (cyc == '1) ? cyc : cyc + IRT_CYC_W'(1);
         waited <= waited || tmr_hold;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   stack_order_a: assert property (
      (st.phase == IRT_STACK && leave && !i_standby)
         |=> st.phase == IRT_VECTOR ##0 $past(cyc) >= 3
   ) else $error("stack phase not followed by vector fetch");
   prio_len_a: assert property (
      (st.phase == IRT_PRIO && leave && !i_standby) |-> int'(cyc) + 1 ==
         ((st.source == IRT_SRC_INT) ? IRT_PRIO_INT_STATES :
          IRT_PRIO_EXT_STATES)
   ) else $error("priority decision length wrong");
   finish_max_a: assert property (
      (st.phase == IRT_FINISH && leave && !i_standby)
         |-> int'(cyc) < fin_max(st.mem)
   ) else $error("instruction tail longer than allowed");
   access_len_a: assert property (
      (st.phase inside {IRT_STACK, IRT_VECTOR, IRT_PREFETCH} && leave
         && !i_standby && !waited)
         |-> cyc == IRT_CYC_W'(acc_len(st.mem))
   ) else $error("memory phase length wrong");
   internal_len_a: assert property (
      (st.phase == IRT_INTERNAL && leave && !i_standby)
         |-> cyc == IRT_CYC_W'(IRT_INTERNAL_STATES - 1) ##1 o_service_start
   ) else $error("internal processing length wrong");
   wait_stretch_a: assert property (
      (tmr_hold && !i_standby) |=> $stable(st.phase)
   ) else $error("phase advanced during a wait state");
   insn_done_a: assert property (
      (st.phase == IRT_FINISH && !i_insn_done) |=> st.phase != IRT_STACK
   ) else $error("stacking began before instruction end");
   mask_set_a: assert property (
      (st.phase == IRT_FINISH && i_insn_done && !i_standby)
         |=> o_int_mask && (o_user_mask_bit || $past(i_user_bit_enable))
   ) else $error("mask bits not set on exception entry");
   nmi_accept_a: assert property (
      (st.phase == IRT_IDLE && i_req.nmi && !i_standby)
         |=> o_accept && o_source == IRT_SRC_NMI
   ) else $error("NMI not accepted");
   disabled_ign_a: assert property (
      (st.phase == IRT_IDLE && !i_req.nmi && !(i_req.irq && i_req.irq_en)
         && !(i_req.intr && i_req.intr_en)) |=> !o_accept
   ) else $error("disabled request was accepted");
   onchip_run_c: cover property (
      o_accept && st.mem == IRT_MEM_ONCHIP ##[19:41] o_service_start
   );
   ext3_wait_c: cover property (st.mem == IRT_MEM_EXT3 && tmr_hold);
   user_lvl1_c: cover property (
      o_accept && o_source == IRT_SRC_IRQ && $past(st.mask)
   );
   nmi_masked_c: cover property (
      o_accept && o_source == IRT_SRC_NMI && $past(st.user_mask)
   );

endmodule

// ---- verif/irt_mem_model.sv ----
// Far-side model: CPU instruction tail and external memory wait requests
module irt_mem_model
   import irt_pkg::*;
(
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_resetn,
   // Sequence phase seen from the block
   input  wire irt_phase_type i_phase,
   // Scenario controls
   input  wire logic [5:0]    i_tail,
   input  wire logic [3:0]    i_waits,
   // Answers to the block
   output logic               o_insn_done,
   output logic               o_wait
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // Cycle counters
   // ----------------------------------------------------------------------
   logic [5:0] fin_cnt; // Cycles spent in the instruction tail
   logic [3:0] stk_cnt; // Cycles spent stacking, saturates
   logic       noise;   // Toggles so ignored lines never look quiet

   // Count cycles per phase; noise drives lines the block must ignore
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fin_cnt <= 6'h00;
         stk_cnt <= 4'h0;
         noise   <= 1'b0;
      end else begin
         noise   <= ~noise;
         fin_cnt <= (i_phase == IRT_FINISH) ? fin_cnt + 6'h01 : 6'h00;
         if (i_phase == IRT_STACK && stk_cnt != 4'hF) begin
            stk_cnt <= stk_cnt + 4'h1;
         end else if (i_phase != IRT_STACK) begin
            stk_cnt <= 4'h0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Answers
   // ----------------------------------------------------------------------
   // Instruction ends after exactly i_tail cycles of the tail phase
   assign o_insn_done = (i_phase == IRT_FINISH) ?
                        (fin_cnt == i_tail - 6'h01) : noise;
   // Wait held during the first stacking cycles; noise where it must not act
   assign o_wait = (i_phase == IRT_STACK) ? (stk_cnt < i_waits) :
                   (i_phase == IRT_VECTOR || i_phase == IRT_PREFETCH) ?
                   1'b0 : noise;
endmodule

// ---- verif/interrupt_response_timing_test.sv ----
// Self-checking bench for the interrupt response sequencer
module interrupt_response_timing_test
   import irt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------------
   logic            clk, resetn, standby, ue, insn_done, acc_wait;
   irt_req_type     req;
   irt_mem_type     mem;
   irt_mask_wr_type mask_wr;
   irt_phase_type   o_phase;
   irt_src_type     o_source;
   logic            o_accept, o_service_start, o_busy;
   logic            o_int_mask, o_user_mask_bit;
   logic [5:0]      tail;
   logic [3:0]      waits;
   int              miscompares, checks;

   // Request encodings: nmi irq irq_en irq_prio1 intr intr_en intr_prio1
   localparam irt_req_type rq_nmi = 7'h40, rq_irq = 7'h30, rq_int = 7'h06;
   localparam irt_req_type rq_irq1 = 7'h38, rq_irq_off = 7'h20;

   irt_exception_seq dut (.i_clk(clk), .i_resetn(resetn), .i_req(req),
      .i_standby(standby), .i_user_bit_enable(ue), .i_mem_type(mem),
      .i_insn_done(insn_done), .i_wait(acc_wait), .i_mask_wr(mask_wr),
      .o_phase(o_phase), .o_source(o_source), .o_accept(o_accept),
      .o_service_start(o_service_start), .o_busy(o_busy),
      .o_int_mask(o_int_mask), .o_user_mask_bit(o_user_mask_bit));

   irt_mem_model partner (.i_clk(clk), .i_resetn(resetn), .i_phase(o_phase),
      .i_tail(tail), .i_waits(waits), .o_insn_done(insn_done),
      .o_wait(acc_wait));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic summarize;
      if (miscompares == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Load both mask bits and see them land one cycle later
   task automatic write_mask(input logic m, input logic u);
      @(negedge clk);
      mask_wr = '{wr: 1'b1, mask: m, user_mask: u};
      @(negedge clk);
      mask_wr = '0;
      check("int_mask", {7'h00, m}, {7'h00, o_int_mask});
      check("user_mask", {7'h00, u}, {7'h00, o_user_mask_bit});
   endtask

   // Hold a request until accepted, or for six cycles if it must be refused
   task automatic take(input irt_req_type r, input logic ok,
                       input irt_src_type src);
      int n;
      @(negedge clk);
      req = r;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (o_accept !== 1'b1 && n < 6);
      check("accept", {7'h00, ok}, {7'h00, o_accept});
      check("busy", {7'h00, ok}, {7'h00, o_busy});
      if (ok) check("source", 8'(src), 8'(o_source));
      req = '0;
   endtask

   // Run one full sequence and measure every phase against its figure
   task automatic run_seq(input irt_req_type r, input irt_src_type src,
                          input irt_mem_type m, input int t, input int w);
      int         len[7];
      int         acc, n;
      logic [2:0] prev, cur;
      logic       um;
      acc = (m == IRT_MEM_ONCHIP) ? IRT_ACC_ONCHIP :
            (m == IRT_MEM_EXT2) ? IRT_ACC_EXT2 : IRT_ACC_EXT3;
      foreach (len[i]) len[i] = 0;
      um = ue ? o_user_mask_bit : 1'b1;
      mem = m;
      tail = 6'(t);
      waits = 4'(w);
      take(r, 1'b1, src);
      prev = 3'(IRT_PRIO);
      n = 0;
      while (o_service_start !== 1'b1 && n < 200) begin
         cur = o_phase;
         if (cur != prev) check("order", 8'(prev + 3'h1), 8'(cur));
         len[cur]++;
         prev = cur;
         n++;
         @(negedge clk);
      end
      if (n >= 200) begin
         miscompares++;
         summarize();
      end
      check("last", 8'(IRT_INTERNAL), 8'(prev));
      check("busy", 8'h00, {7'h00, o_busy});
      check("prio", 8'((src == IRT_SRC_INT) ? IRT_PRIO_INT_STATES :
            IRT_PRIO_EXT_STATES), 8'(len[1]));
      check("finish", 8'(t), 8'(len[2]));
      check("stack", 8'(acc + ((m != IRT_MEM_ONCHIP) ? w : 0)),
            8'(len[3]));
      check("vector", 8'(acc), 8'(len[4]));
      check("prefetch", 8'(acc), 8'(len[5]));
      check("internal", 8'(IRT_INTERNAL_STATES), 8'(len[6]));
      check("mask_set", 8'h01, {7'h00, o_int_mask});
      check("umask_set", {7'h00, um}, {7'h00, o_user_mask_bit});
      @(negedge clk);
      check("svc_pulse", 8'h00, {7'h00, o_service_start});
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Standby in mid-sequence drops back to idle with no service start
   task automatic standby_abort;
      int n;
      write_mask(1'b0, 1'b0);
      mem = IRT_MEM_EXT3;
      take(rq_irq, 1'b1, IRT_SRC_IRQ);
      n = 0;
      while (o_phase !== IRT_STACK && n < 40) begin
         @(negedge clk);
         n++;
      end
      // Never reached stacking: count it and stop here
      if (n >= 40) begin
         miscompares++;
         summarize();
      end
      standby = 1'b1;
      @(negedge clk);
      check("abort_phase", 8'(IRT_IDLE), 8'(o_phase));
      check("abort_svc", 8'h00, {7'h00, o_service_start});
      take(rq_nmi, 1'b0, IRT_SRC_NMI);
      standby = 1'b0;
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      miscompares = 0;
      checks = 0;
      resetn = 1'b0;
      standby = 1'b0;
      ue = 1'b1;
      req = '0;
      mem = IRT_MEM_ONCHIP;
      mask_wr = '0;
      tail = 6'h01;
      waits = 4'h0;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      check("rst_phase", 8'(IRT_IDLE), 8'(o_phase));
      check("rst_mask", 8'h01, {7'h00, o_int_mask});
      // Masked and disabled sources are refused
      take(rq_irq, 1'b0, IRT_SRC_IRQ);
      take(rq_int, 1'b0, IRT_SRC_INT);
      write_mask(1'b0, 1'b0);
      take(rq_irq_off, 1'b0, IRT_SRC_IRQ);
      standby = 1'b1;
      take(rq_nmi, 1'b0, IRT_SRC_NMI);
      standby = 1'b0;
      // Every memory type at its longest tail, waits on stacking, then a one-cycle on-chip tail
      write_mask(1'b0, 1'b0);
      run_seq(rq_irq, IRT_SRC_IRQ, IRT_MEM_ONCHIP, 23, 3);
      write_mask(1'b0, 1'b0);
      run_seq(rq_irq, IRT_SRC_IRQ, IRT_MEM_EXT2, 27, 2);
      write_mask(1'b0, 1'b0);
      run_seq(rq_int, IRT_SRC_INT, IRT_MEM_EXT3, 31, 3);
      write_mask(1'b0, 1'b0);
      run_seq(rq_int, IRT_SRC_INT, IRT_MEM_ONCHIP, 1, 0);
      // Non-maskable gets in with the mask set
      run_seq(rq_nmi, IRT_SRC_NMI, IRT_MEM_EXT2, 5, 0);
      // Priority among simultaneous requests
      write_mask(1'b0, 1'b0);
      run_seq(7'h70, IRT_SRC_NMI, IRT_MEM_ONCHIP, 2, 0);
      write_mask(1'b0, 1'b0);
      run_seq(7'h36, IRT_SRC_IRQ, IRT_MEM_ONCHIP, 2, 0);
      // Three-level masking: level 1 passes, level 0 waits
      ue = 1'b0;
      write_mask(1'b1, 1'b0);
      take(rq_irq, 1'b0, IRT_SRC_IRQ);
      run_seq(rq_irq1, IRT_SRC_IRQ, IRT_MEM_EXT3, 4, 1);
      take(rq_irq1, 1'b0, IRT_SRC_IRQ);
      // On-chip sources: level 0 waits, level 1 passes with user mask clear
      write_mask(1'b1, 1'b0);
      take(rq_int, 1'b0, IRT_SRC_INT);
      run_seq(7'h07, IRT_SRC_INT, IRT_MEM_EXT2, 3, 1);
      ue = 1'b1;
      standby_abort();
      summarize();
   end
endmodule
